// ### core/lcd_setup_map.vh
`ifndef LCD_SETUP_MAP_VH
`define LCD_SETUP_MAP_VH

// instruction codes that pick the destination data register
`define CODE_MODE_CONTROL     8'h00
`define CODE_CHAR_PITCH       8'h01
`define CODE_CHARS_PER_LINE   8'h02

// mode byte fields
`define MODE_DISPLAY_ON_BIT   5
`define MODE_MASTER_BIT       4
`define MODE_CURSOR_HI_BIT    3
`define MODE_CURSOR_LO_BIT    2
`define MODE_GRAPHIC_BIT      1
`define MODE_CG_SOURCE_BIT    0

// character pitch fields
`define PITCH_HEIGHT_HI       7
`define PITCH_HEIGHT_LO       4
`define PITCH_WIDTH_HI        2
`define PITCH_WIDTH_LO        0

// cursor/blink encodings
`define CURSOR_OFF            2'h0
`define CURSOR_ON             2'h1
`define CURSOR_CHAR_BLINK     2'h2
`define CURSOR_BLINK          2'h3

// allowed horizontal pitch codes
`define WIDTH_CODE_6          3'h5
`define WIDTH_CODE_7          3'h6
`define WIDTH_CODE_8          3'h7

// reset values
`define MODE_RESET            8'h00
`define PITCH_RESET           8'h77
`define CHARS_RESET           8'h01
`define HEIGHT_RESET          5'h08
`define WIDTH_RESET           4'h8
`define COUNT_RESET           8'h02
`define DOTS_RESET            11'h010

// busy time after a data write, ns, and its cycle count at 125 MHz
`define CLK_PERIOD_NS         8
`define EXEC_TIME_NS          1000
`define EXEC_CYCLES           ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### core/sync_2ff.v
`timescale 1ns/10ps
module sync_2ff #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ### core/lcd_display_setup_commands.v
`timescale 1ns/10ps
`include "lcd_setup_map.vh"
module lcd_display_setup_commands #(
  parameter EXEC_CYCLES = `EXEC_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        chip_select_b,
  input  wire        enable,
  input  wire        register_select_line,
  input  wire        read_not_write,
  input  wire [7:0]  host_data_bus_in,
  output reg  [7:0]  host_data_bus_out,
  output reg         host_data_bus_oe_b,
  output reg         busy,
  output reg  [7:0]  mode_control,
  output reg  [7:0]  character_pitch,
  output reg  [7:0]  characters_per_line,
  output reg         display_on,
  output reg         master_mode,
  output reg         graphic_mode,
  output reg         char_pattern_source,
  output reg         cursor_visible,
  output reg         cursor_blink,
  output reg         char_blink,
  output reg  [4:0]  char_cell_height,
  output reg  [3:0]  char_cell_width,
  output reg  [7:0]  chars_per_line,
  output reg  [10:0] line_dots,
  output reg         setting_error
);

  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  wire [11:0] pins_sync;
  wire        cs_b_s;
  wire        en_s;
  wire        rs_s;
  wire        rw_s;
  wire [7:0]  din_s;

  // pins cross in as one group; bus setup times keep them stable around enable
  sync_2ff #(
    .WIDTH (12)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({chip_select_b, enable, register_select_line, read_not_write, host_data_bus_in}),
    .sync_out (pins_sync)
  );

  assign cs_b_s = pins_sync[11];
  assign en_s   = pins_sync[10];
  assign rs_s   = pins_sync[9];
  assign rw_s   = pins_sync[8];
  assign din_s  = pins_sync[7:0];

  reg        en_d_reg;
  reg        cs_b_d_reg;
  reg        rs_d_reg;
  reg        rw_d_reg;
  reg [7:0]  din_d_reg;
  reg [7:0]  instr_reg;
  reg [7:0]  instr_next;
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg [7:0]  mode_next;
  reg [7:0]  pitch_next;
  reg [7:0]  chars_next;
  reg        err_next;

  // data is latched on the falling edge of enable, like the host bus expects
  wire strobe  = en_d_reg & ~en_s & ~cs_b_d_reg;
  wire wr_cmd  = strobe & ~rw_d_reg & rs_d_reg;
  wire wr_data = strobe & ~rw_d_reg & ~rs_d_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_d_reg   <= 1'b0;
      cs_b_d_reg <= 1'b1;
      rs_d_reg   <= 1'b0;
      rw_d_reg   <= 1'b1;
      din_d_reg  <= 8'h00;
    end else begin
      en_d_reg   <= en_s;
      cs_b_d_reg <= cs_b_s;
      rs_d_reg   <= rs_s;
      rw_d_reg   <= rw_s;
      din_d_reg  <= din_s;
    end
  end

  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    instr_next = instr_reg;
    mode_next  = mode_control;
    pitch_next = character_pitch;
    chars_next = characters_per_line;
    err_next   = setting_error;
    case (state_reg)
      ST_IDLE: begin
        if (wr_cmd) begin
          instr_next = din_d_reg;
        end else if (wr_data) begin
          case (instr_reg)
            `CODE_MODE_CONTROL: begin
              mode_next = {2'b00, din_d_reg[5:0]};
            end
            `CODE_CHAR_PITCH: begin
              pitch_next = {din_d_reg[7:4], 1'b0, din_d_reg[2:0]};
              // out-of-range width codes are kept but flagged
              err_next = (din_d_reg[2:0] < `WIDTH_CODE_6);
            end
            `CODE_CHARS_PER_LINE: begin
              chars_next = {1'b0, din_d_reg[6:0]};
              err_next   = ~din_d_reg[0];
            end
            default: begin
              // codes owned by other blocks still run the busy period
              mode_next = mode_control;
            end
          endcase
          state_next = ST_EXEC;
          count_next = EXEC_CYCLES[15:0] - 16'h0001;
        end
      end
      ST_EXEC: begin
        // writes while executing are dropped, not queued
        if (count_reg == 16'h0000) begin
          state_next = ST_IDLE;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        count_next = 16'h0000;
      end
    endcase
  end

  reg         cursor_visible_next;
  reg         cursor_blink_next;
  reg         char_blink_next;
  reg  [4:0]  height_next;
  reg  [3:0]  width_next;
  reg         status_oe_next;
  reg  [7:0]  status_next;
  wire [7:0]  chars_dec;
  wire [11:0] dots_full;

  // cursor and blink only mean something in character mode
  always @* begin
    cursor_visible_next = 1'b0;
    cursor_blink_next   = 1'b0;
    char_blink_next     = 1'b0;
    if (!mode_next[`MODE_GRAPHIC_BIT]) begin
      case (mode_next[`MODE_CURSOR_HI_BIT:`MODE_CURSOR_LO_BIT])
        `CURSOR_OFF: begin
          cursor_visible_next = 1'b0;
        end
        `CURSOR_ON: begin
          cursor_visible_next = 1'b1;
        end
        `CURSOR_CHAR_BLINK: begin
          char_blink_next = 1'b1;
        end
        `CURSOR_BLINK: begin
          cursor_visible_next = 1'b1;
          cursor_blink_next   = 1'b1;
        end
        default: begin
          cursor_visible_next = 1'b0;
        end
      endcase
    end
  end

  // codes under 101 are outside the allowed pitches but still decode as code plus one
  always @* begin
    case (pitch_next[`PITCH_WIDTH_HI:`PITCH_WIDTH_LO])
      `WIDTH_CODE_6: begin
        width_next = 4'h6;
      end
      `WIDTH_CODE_7: begin
        width_next = 4'h7;
      end
      `WIDTH_CODE_8: begin
        width_next = 4'h8;
      end
      default: begin
        width_next = {1'b0, pitch_next[`PITCH_WIDTH_HI:`PITCH_WIDTH_LO]} + 4'h1;
      end
    endcase
    // graphic mode uses one dot row per byte line
    if (mode_next[`MODE_GRAPHIC_BIT]) begin
      height_next = 5'h01;
    end else begin
      height_next = {1'b0, pitch_next[`PITCH_HEIGHT_HI:`PITCH_HEIGHT_LO]} + 5'h01;
    end
  end

  // status read: busy in bit 7, driven while enable is high on an instruction-side read
  always @* begin
    status_oe_next = en_s & ~cs_b_s & rw_s & rs_s;
    status_next    = 8'h00;
    status_next[7] = busy;
  end

  assign chars_dec = chars_next + 8'h01;
  assign dots_full = chars_dec * width_next;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      instr_reg <= 8'h00;
      busy      <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      instr_reg <= instr_next;
      busy      <= (state_next == ST_EXEC);
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_control        <= `MODE_RESET;
      character_pitch     <= `PITCH_RESET;
      characters_per_line <= `CHARS_RESET;
    end else begin
      mode_control        <= mode_next;
      character_pitch     <= pitch_next;
      characters_per_line <= chars_next;
    end
  end

  // holds until the next pitch or count write replaces it
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setting_error <= 1'b0;
    end else begin
      setting_error <= err_next;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      display_on          <= 1'b0;
      master_mode         <= 1'b0;
      graphic_mode        <= 1'b0;
      char_pattern_source <= 1'b0;
      cursor_visible      <= 1'b0;
      cursor_blink        <= 1'b0;
      char_blink          <= 1'b0;
    end else begin
      display_on          <= mode_next[`MODE_DISPLAY_ON_BIT];
      master_mode         <= mode_next[`MODE_MASTER_BIT];
      graphic_mode        <= mode_next[`MODE_GRAPHIC_BIT];
      char_pattern_source <= mode_next[`MODE_CG_SOURCE_BIT];
      cursor_visible      <= cursor_visible_next;
      cursor_blink        <= cursor_blink_next;
      char_blink          <= char_blink_next;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      char_cell_height    <= `HEIGHT_RESET;
      char_cell_width     <= `WIDTH_RESET;
      chars_per_line      <= `COUNT_RESET;
      line_dots           <= `DOTS_RESET;
    end else begin
      char_cell_height    <= height_next;
      char_cell_width     <= width_next;
      chars_per_line      <= chars_dec;
      line_dots           <= dots_full[10:0];
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_data_bus_out   <= 8'h00;
      host_data_bus_oe_b  <= 1'b1;
    end else begin
      host_data_bus_out   <= status_next;
      host_data_bus_oe_b  <= ~status_oe_next;
    end
  end

endmodule

// ### tb/lcd_setup_monitor.sv
`timescale 1ns/10ps
module lcd_setup_monitor #(
  parameter EXEC_CYCLES = 125
) (
  input wire        core_clk,
  input wire        rst_b,
  input wire        chip_select_b,
  input wire        enable,
  input wire        register_select_line,
  input wire        read_not_write,
  input wire [7:0]  host_data_bus_out,
  input wire        host_data_bus_oe_b,
  input wire        busy,
  input wire [7:0]  mode_control,
  input wire [7:0]  character_pitch,
  input wire [7:0]  characters_per_line,
  input wire        display_on,
  input wire        master_mode,
  input wire        graphic_mode,
  input wire        char_pattern_source,
  input wire        cursor_visible,
  input wire        cursor_blink,
  input wire        char_blink,
  input wire [4:0]  char_cell_height,
  input wire [3:0]  char_cell_width,
  input wire [7:0]  chars_per_line,
  input wire [10:0] line_dots
);
  reg [15:0] run_reg;
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b) run_reg <= 16'h0000;
    else run_reg <= busy ? run_reg + 16'h0001 : 16'h0000;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence exec_done; $fell(busy); endsequence
  sequence cfg_moved;
    $changed(mode_control) || $changed(character_pitch) || $changed(characters_per_line);
  endsequence
  busy_length_a: assert property (exec_done |-> run_reg == EXEC_CYCLES) else $error("busy length");
  busy_cap_a: assert property (busy |-> run_reg < EXEC_CYCLES) else $error("busy too long");
  cfg_exec_a: assert property (cfg_moved |-> $rose(busy)) else $error("config without execution");
  busy_lock_a: assert property (busy && $past(busy) |-> $stable(mode_control) && $stable(character_pitch)
    && $stable(characters_per_line)) else $error("write taken while busy");
  mode_bits_a: assert property (mode_control[7:6] == 2'h0 && display_on == mode_control[5]
    && master_mode == mode_control[4] && graphic_mode == mode_control[1]
    && char_pattern_source == mode_control[0]) else $error("mode bits");
  cursor_code_a: assert property (cursor_blink == (!graphic_mode && mode_control[3:2] == 2'h3)
    && char_blink == (!graphic_mode && mode_control[3:2] == 2'h2)
    && cursor_visible == (!graphic_mode && (mode_control[3:2] == 2'h1 || mode_control[3:2] == 2'h3)))
    else $error("cursor decode");
  pitch_fields_a: assert property (character_pitch[3] == 1'b0
    && char_cell_width == {1'b0, character_pitch[2:0]} + 4'h1
    && char_cell_height == (graphic_mode ? 5'h01 : {1'b0, character_pitch[7:4]} + 5'h01)) else $error("pitch");
  line_count_a: assert property (characters_per_line[7] == 1'b0
    && chars_per_line == characters_per_line + 8'h01
    && line_dots == chars_per_line * char_cell_width) else $error("line count");
  status_read_a: assert property ($fell(host_data_bus_oe_b) |-> $past(enable, 3) && !$past(chip_select_b, 3)
    && $past(read_not_write, 3) && $past(register_select_line, 3) && host_data_bus_out[6:0] == 7'h00)
    else $error("status drive");
endmodule
bind lcd_display_setup_commands lcd_setup_monitor #(.EXEC_CYCLES(EXEC_CYCLES)) monitor (.*);

// ### tb/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model (
  input  wire       core_clk,
  input  wire [7:0] bus_level,
  output reg        chip_select_b,
  output reg        enable,
  output reg        register_select_line,
  output reg        read_not_write,
  output reg  [7:0] drive_data,
  output reg        drive_on
);
  initial begin
    chip_select_b = 1'b1;
    enable = 1'b0;
    register_select_line = 1'b0;
    read_not_write = 1'b1;
    drive_data = 8'hFF;
    drive_on = 1'b0;
  end
  // pins settle a cycle before enable and hold three cycles past its fall
  task access(input bit rs, input bit rw, input [7:0] d, output [7:0] q);
    begin
      @(posedge core_clk);
      chip_select_b <= 1'b0;
      register_select_line <= rs;
      read_not_write <= rw;
      drive_data <= d;
      drive_on <= !rw;
      @(posedge core_clk);
      enable <= 1'b1;
      repeat (6) @(posedge core_clk);
      q = bus_level;
      enable <= 1'b0;
      repeat (3) @(posedge core_clk);
      chip_select_b <= 1'b1;
      drive_on <= 1'b0;
    end
  endtask
  task put(input bit rs, input [7:0] d);
    reg [7:0] q;
    access(rs, 1'b0, d, q);
  endtask
  task wait_idle(output bit ok);
    reg [7:0] q;
    int n;
    begin
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
        access(1'b1, 1'b1, 8'hFF, q);
        ok = (q[7] === 1'b0);
      end
    end
  endtask
endmodule

// ### tb/lcd_display_setup_commands_test.sv
`timescale 1ns/10ps
module lcd_display_setup_commands_test;
  reg         core_clk, rst_b;
  reg  [7:0]  m, p, c, q;
  reg  [2:0]  w;
  int         i, r, fail_count, samples_checked;
  wire        chip_select_b, enable, register_select_line, read_not_write, drive_on, host_data_bus_oe_b, busy;
  wire        display_on, master_mode, graphic_mode, char_pattern_source, cursor_visible, cursor_blink;
  wire        char_blink, setting_error;
  wire [7:0]  drive_data, host_data_bus_in, host_data_bus_out, mode_control, character_pitch;
  wire [7:0]  characters_per_line, chars_per_line;
  wire [4:0]  char_cell_height;
  wire [3:0]  char_cell_width;
  wire [10:0] line_dots;
  // data pins carry pull-ups, so a released bus reads all ones
  assign host_data_bus_in = !host_data_bus_oe_b ? host_data_bus_out : drive_on ? drive_data : 8'hFF;
  lcd_display_setup_commands #(.EXEC_CYCLES(40)) uut (.*);
  host_cpu_model host (.bus_level(host_data_bus_in), .*);
  function [10:0] exp_dots(input [7:0] cf, input [2:0] wf);
    exp_dots = ({3'h0, cf} + 11'h001) * ({8'h00, wf} + 11'h001);
  endfunction
  function [1:0] exp_blink(input [7:0] md);
    exp_blink = md[1] ? 2'h0 : {md[3:2] == 2'h3, md[3:2] == 2'h2};
  endfunction
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input [10:0] seen, input [10:0] want);
    begin
      samples_checked++;
      if (seen !== want) begin
        fail_count++;
        $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task idle;
    bit ok;
    begin
      host.wait_idle(ok);
      if (!ok) begin
        fail_count++;
        print_verdict;
      end
    end
  endtask
  task setup(input [7:0] code, input [7:0] data);
    begin
      idle;
      host.put(1'b1, code);
      host.put(1'b0, data);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    rst_b = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    r = $urandom(34);
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    check(busy, 11'h000);
    check(line_dots, 11'h010);
    for (i = 0; i < 12; i++) begin
      m = {2'h0, 2'($urandom), i[1:0], i[2], 1'($urandom)};
      w = 3'h5 + 3'($urandom % 3);
      p = {4'($urandom), 1'b0, w};
      c = {1'b0, 6'($urandom), 1'b1};
      if (i == 1) c = 8'h7F;
      setup(8'h00, m);
      setup(8'h01, p);
      setup(8'h02, c);
      idle;
      check(mode_control, m);
      check(character_pitch, p);
      check(characters_per_line, c);
      check(line_dots, exp_dots(c, w));
      check(char_cell_height, m[1] ? 5'h01 : p[7:4] + 5'h01);
      check({cursor_blink, char_blink}, exp_blink(m));
      check(setting_error, 11'h000);
    end
    setup(8'h01, 8'h65);
    host.put(1'b0, 8'h76);
    host.access(1'b1, 1'b1, 8'hFF, q);
    check(q, 8'h80);
    idle;
    check(character_pitch, 8'h65);
    host.put(1'b0, 8'h76);
    idle;
    check(character_pitch, 8'h76);
    setup(8'h0C, 8'h00);
    idle;
    check(mode_control, m);
    check(characters_per_line, c);
    setup(8'h02, 8'h10);
    idle;
    check(setting_error, 11'h001);
    print_verdict;
  end
endmodule
